/* File: pkg/led_sink_pkg.sv */
// Constants shared by the serial-in latched LED sink driver.
// Assumes one system clock; all pins arrive asynchronously.
`default_nettype none

package led_sink_pkg;

	// ************************************************************
	// Structure
	// ************************************************************
	localparam int unsigned STAGE_COUNT = 8;
	localparam int unsigned SYNC_DEPTH  = 3;
	localparam int unsigned PIN_COUNT   = 5;

	// Packed pin order: {clear_n, output_disable, latch, serial bit, shift clock}
	localparam int unsigned PIN_SHIFT_CLK = 0;
	localparam int unsigned PIN_SERIAL    = 1;
	localparam int unsigned PIN_LATCH     = 2;
	localparam int unsigned PIN_DISABLE   = 3;
	localparam int unsigned PIN_CLEAR_N   = 4;

	// ************************************************************
	// Reset values
	// ************************************************************
	// Clear held asserted and outputs disabled until real pin levels arrive
	localparam logic [PIN_COUNT-1:0]   PIN_RESET   = 5'h08;
	localparam logic [STAGE_COUNT-1:0] STAGE_RESET = 8'h00;
	localparam logic                   CASCADE_OFF = 1'b0;
	localparam logic                   SINK_LEVEL  = 1'b0;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int unsigned SYS_CLK_HZ        = 20_000_000;
	localparam int unsigned SHIFT_CLK_MAX_HZ  = 10_000_000;
	localparam int unsigned SHIFT_CLK_MIN_CYC = (SYS_CLK_HZ + SHIFT_CLK_MAX_HZ - 1)
		/ SHIFT_CLK_MAX_HZ;

endpackage

`default_nettype wire

/* File: pkg/led_sink_if.sv */
// Internal carriers between the driver core and its helper modules.
// Assumes both ends sit on sys_clk.
`timescale 1ns/10ps
`default_nettype none

interface pin_level_if;
	import led_sink_pkg::*;
	logic [PIN_COUNT-1:0] level;
	modport src (output level);
	modport dst (input level);
endinterface

interface shift_chain_if;
	import led_sink_pkg::*;
	logic                   shift_pulse;
	logic                   data_bit;
	logic                   clear_now;
	logic [STAGE_COUNT-1:0] stages;
	modport ctl   (output shift_pulse, output data_bit, output clear_now, input stages);
	modport chain (input shift_pulse, input data_bit, input clear_now, output stages);
endinterface

`default_nettype wire

/* File: rtl/pin_filter.sv */
// Three-flop synchronisers for the asynchronous control pins.
// Assumes pins are quasi-static relative to sys_clk over a few cycles.
`timescale 1ns/10ps
`default_nettype none

module pin_filter
	import led_sink_pkg::*;
(
	input  wire logic                 sys_clk,
	input  wire logic                 reset_n,
	input  wire logic [PIN_COUNT-1:0] pins,
	pin_level_if.src                  out
);

	logic [PIN_COUNT-1:0] s1_q, s2_q, s3_q, lvl_q;
	logic [PIN_COUNT-1:0] s1_d, s2_d, s3_d, lvl_d;

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		s1_d = pins;
		s2_d = s1_q;
		s3_d = s2_q;
		lvl_d = lvl_q;
		// Only accept a level once two settled stages agree
		for (int i = 0; i < PIN_COUNT; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				lvl_d[i] = s3_q[i];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			s1_q  <= PIN_RESET;
			s2_q  <= PIN_RESET;
			s3_q  <= PIN_RESET;
			lvl_q <= PIN_RESET;
		end else begin
			s1_q  <= s1_d;
			s2_q  <= s2_d;
			s3_q  <= s3_d;
			lvl_q <= lvl_d;
		end
	end

	assign out.level = lvl_q;

endmodule

`default_nettype wire

/* File: rtl/shift_chain.sv */
// Eight-stage serial shift rank; stage 0 is the first position.
// Assumes shift_pulse is a one-cycle strobe from the core.
`timescale 1ns/10ps
`default_nettype none

module shift_chain
	import led_sink_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic reset_n,
	shift_chain_if.chain ch
);

	logic [STAGE_COUNT-1:0] stage_q, stage_d;

	always_comb begin
		stage_d = stage_q;
		// Clear dominates a coincident shift
		if (ch.clear_now) begin
			stage_d = STAGE_RESET;
		end else if (ch.shift_pulse) begin
			stage_d = {stage_q[STAGE_COUNT-2:0], ch.data_bit};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			stage_q <= STAGE_RESET;
		end else begin
			stage_q <= stage_d;
		end
	end

	assign ch.stages = stage_q;

endmodule

`default_nettype wire

/* File: rtl/serial_in_latched_led_sink_driver.sv */
// Serial-in, latched, open-drain LED sink driver with cascade output.
// Assumes all control pins are asynchronous to sys_clk and change
// no faster than the shift clock limit allows.
`timescale 1ns/10ps
`default_nettype none

// Function
// - Two eight-bit ranks: shift register feeding an output latch.
// - Shift clock rising edge loads input bit, moves stored bits onward.
// - First bit in lands at first sink, then moves toward eighth.
// - Cascade output shows the final shift stage.
// - Cascade output changes only after a shift clock falling edge or under clear.
// - Latch input low holds latch and sink outputs.
// - Latch input high makes latch follow the shift register.
// - Latch input rising edge transfers shift contents to sinks.
// - Disable high forces all eight sinks off.
// - Disable low lets each sink show its held bit.
// - Sink level is inverse of bit; set bit sinks and lights.
// - Clear low empties both ranks without waiting for shift clock.
// - Clear low holds all sinks and cascade output off.
module serial_in_latched_led_sink_driver
	import led_sink_pkg::*;
(
	input  wire logic                   sys_clk,
	input  wire logic                   reset_n,
	input  wire logic                   serial_bit_in,
	input  wire logic                   shift_clk,
	input  wire logic                   latch_in,
	input  wire logic                   output_disable,
	input  wire logic                   clear_n,
	output var  logic [STAGE_COUNT-1:0] led_sink_out,
	output var  logic [STAGE_COUNT-1:0] led_sink_oe,
	output var  logic                   cascade_out
);

	// ************************************************************
	// Pin conditioning
	// ************************************************************
	pin_level_if   pins_if ();
	shift_chain_if chain_if ();

	logic [PIN_COUNT-1:0] pin_raw;
	logic sck_lvl, bit_lvl, latch_lvl, disable_lvl, clear_lvl_n;

	assign pin_raw[PIN_SHIFT_CLK] = shift_clk;
	assign pin_raw[PIN_SERIAL]    = serial_bit_in;
	assign pin_raw[PIN_LATCH]     = latch_in;
	assign pin_raw[PIN_DISABLE]   = output_disable;
	assign pin_raw[PIN_CLEAR_N]   = clear_n;

	pin_filter u_pin_filter (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.pins    (pin_raw),
		.out     (pins_if.src)
	);

	assign sck_lvl     = pins_if.level[PIN_SHIFT_CLK];
	assign bit_lvl     = pins_if.level[PIN_SERIAL];
	assign latch_lvl   = pins_if.level[PIN_LATCH];
	assign disable_lvl = pins_if.level[PIN_DISABLE];
	assign clear_lvl_n = pins_if.level[PIN_CLEAR_N];

	// ************************************************************
	// Shift clock edges
	// ************************************************************
	logic sck_prev_q, sck_prev_d;
	logic sck_rise, sck_fall;

	// Data and clock share one sync path, so setup at the pin is kept
	assign sck_rise = sck_lvl & ~sck_prev_q;
	assign sck_fall = ~sck_lvl & sck_prev_q;

	always_comb begin
		sck_prev_d = sck_lvl;
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			sck_prev_q <= 1'b0;
		end else begin
			sck_prev_q <= sck_prev_d;
		end
	end

	// ************************************************************
	// Shift rank
	// ************************************************************
	assign chain_if.shift_pulse = sck_rise;
	assign chain_if.data_bit    = bit_lvl;
	assign chain_if.clear_now   = ~clear_lvl_n;

	shift_chain u_shift_chain (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.ch      (chain_if.chain)
	);

	// ************************************************************
	// Output latch, cascade and sinks
	// ************************************************************
	logic [STAGE_COUNT-1:0] latch_q, latch_d;
	logic [STAGE_COUNT-1:0] oe_q, oe_d;
	logic [STAGE_COUNT-1:0] sink_q, sink_d;
	logic                   cascade_q, cascade_d;

	always_comb begin
		latch_d   = latch_q;
		cascade_d = cascade_q;
		oe_d      = latch_q;
		sink_d    = {STAGE_COUNT{SINK_LEVEL}};
		if (!clear_lvl_n) begin
			latch_d   = STAGE_RESET;
			cascade_d = CASCADE_OFF;
			oe_d      = '0;
		end else begin
			// Transparent while high, covers the rising-edge transfer too
			if (latch_lvl) begin
				latch_d = chain_if.stages;
			end
			// Launch on the falling edge: half a period of hold downstream
			if (sck_fall) begin
				cascade_d = chain_if.stages[STAGE_COUNT-1];
			end
			// Gates drivers only; ranks are untouched
			if (disable_lvl) begin
				oe_d = '0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			latch_q   <= STAGE_RESET;
			cascade_q <= CASCADE_OFF;
			oe_q      <= '0;
			sink_q    <= {STAGE_COUNT{SINK_LEVEL}};
		end else begin
			latch_q   <= latch_d;
			cascade_q <= cascade_d;
			oe_q      <= oe_d;
			sink_q    <= sink_d;
		end
	end

	// Open drain: enable high pulls the pin low, so pin level is ~bit
	assign led_sink_out = sink_q;
	assign led_sink_oe  = oe_q;
	assign cascade_out  = cascade_q;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	a_shift_step: assert property (
		sck_rise && clear_lvl_n |=> chain_if.stages ==
			{$past(chain_if.stages[STAGE_COUNT-2:0]), $past(bit_lvl)})
		else $error("shift rank did not step on clock rise");

	a_first_position: assert property (
		sck_rise && clear_lvl_n |=> chain_if.stages[0] == $past(bit_lvl))
		else $error("new bit missing from first stage");

	a_shift_idle: assert property (
		!sck_rise && clear_lvl_n |=> $stable(chain_if.stages))
		else $error("shift rank moved without a clock rise");

	a_cascade_source: assert property (
		sck_fall && clear_lvl_n |=> cascade_q == $past(chain_if.stages[STAGE_COUNT-1]))
		else $error("cascade output not final stage after fall");

	a_cascade_steady: assert property (
		!sck_fall && clear_lvl_n |=> $stable(cascade_q))
		else $error("cascade output changed without a clock fall");

	a_latch_hold: assert property (
		!latch_lvl && clear_lvl_n |=> $stable(latch_q))
		else $error("latch changed while latch input low");

	a_latch_follow: assert property (
		latch_lvl && clear_lvl_n |=> latch_q == $past(chain_if.stages))
		else $error("latch not transparent while latch input high");

	a_latch_rise_sink: assert property (
		$rose(latch_lvl) && clear_lvl_n && !disable_lvl
		##1 clear_lvl_n && !disable_lvl |=> oe_q == $past(chain_if.stages, 2))
		else $error("latch rise did not reach sink outputs");

	a_disable_off: assert property (
		disable_lvl |=> oe_q == '0)
		else $error("sinks active while disabled");

	a_enabled_show: assert property (
		!disable_lvl && clear_lvl_n |=> oe_q == $past(latch_q))
		else $error("enabled sinks do not match latch");

	a_sink_polarity: assert property (
		led_sink_out == '0 && (oe_q & ~$past(latch_q)) == '0)
		else $error("sink drives high or lights a clear bit");

	a_clear_ranks: assert property (
		!clear_lvl_n |=> chain_if.stages == '0 && latch_q == '0)
		else $error("clear did not empty both ranks");

	a_clear_outputs: assert property (
		!clear_lvl_n [*2] |-> oe_q == '0 && cascade_q == CASCADE_OFF)
		else $error("outputs active during clear");

	a_disable_keeps: assert property (
		$changed(disable_lvl) && clear_lvl_n && !latch_lvl && !sck_rise
		|=> $stable(latch_q) && $stable(chain_if.stages))
		else $error("disable toggle altered stored data");

	c_latch_rise: cover property ($rose(latch_lvl) && clear_lvl_n);
	c_cascade_move: cover property (sck_fall && clear_lvl_n ##1 $changed(cascade_q));
	c_disable_toggle: cover property (disable_lvl ##1 !disable_lvl ##1 oe_q != '0);
	c_clear_release: cover property (!clear_lvl_n ##1 clear_lvl_n);

endmodule

`default_nettype wire

/* File: bench/host_model.sv */
// Host controller model driving the serial, shift clock, latch, disable and clear pins.
// Assumes pins change just after a rising sys_clk edge, by non-blocking assignment.
`timescale 1ns/10ps
`default_nettype none

module host_model (
	input  wire logic sys_clk,
	output var  logic serial_bit_in,
	output var  logic shift_clk,
	output var  logic latch_in,
	output var  logic output_disable,
	output var  logic clear_n
);
	// Clear low from power-up until the bench lets go
	initial begin
		serial_bit_in  = 1'b0;
		shift_clk      = 1'b0;
		latch_in       = 1'b0;
		output_disable = 1'b1;
		clear_n        = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// Data two cycles ahead of the rise, for setup
	task automatic rise(input logic b);
		@(posedge sys_clk);
		serial_bit_in <= b;
		wait_clk(2);
		shift_clk <= 1'b1;
	endtask

	// Data line drops to its pull-down level once hold has run out
	task automatic fall();
		@(posedge sys_clk);
		shift_clk <= 1'b0;
		wait_clk(2);
		serial_bit_in <= 1'b0;
	endtask

	task automatic set_ctl(input logic lat, input logic dis, input logic clr);
		@(posedge sys_clk);
		latch_in       <= lat;
		output_disable <= dis;
		clear_n        <= clr;
	endtask
endmodule

`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench for the serial-in latched LED sink driver.
// Assumes host_model drives every pin; sys_clk at 20 MHz.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	import led_sink_pkg::*;
	logic                   sys_clk;
	logic                   reset_n;
	logic                   serial_bit_in;
	logic                   shift_clk;
	logic                   latch_in;
	logic                   output_disable;
	logic                   clear_n;
	logic                   cascade_out;
	logic [STAGE_COUNT-1:0] led_sink_out;
	logic [STAGE_COUNT-1:0] led_sink_oe;
	logic [STAGE_COUNT-1:0] next_oe;
	logic [STAGE_COUNT-1:0] exp_stages;
	int                     failures;
	int                     tests_run;

	always #25 sys_clk = ~sys_clk;

	host_model host (
		.sys_clk        (sys_clk),
		.serial_bit_in  (serial_bit_in),
		.shift_clk      (shift_clk),
		.latch_in       (latch_in),
		.output_disable (output_disable),
		.clear_n        (clear_n)
	);

	serial_in_latched_led_sink_driver DUT (
		.sys_clk        (sys_clk),
		.reset_n        (reset_n),
		.serial_bit_in  (serial_bit_in),
		.shift_clk      (shift_clk),
		.latch_in       (latch_in),
		.output_disable (output_disable),
		.clear_n        (clear_n),
		.led_sink_out   (led_sink_out),
		.led_sink_oe    (led_sink_oe),
		.cascade_out    (cascade_out)
	);

	// Second device in the chain: cascade feeds its serial input, clocks shared
	serial_in_latched_led_sink_driver DUT_NEXT (
		.sys_clk        (sys_clk),
		.reset_n        (reset_n),
		.serial_bit_in  (cascade_out),
		.shift_clk      (shift_clk),
		.latch_in       (latch_in),
		.output_disable (output_disable),
		.clear_n        (clear_n),
		.led_sink_out   (),
		.led_sink_oe    (next_oe),
		.cascade_out    ()
	);

	// *****
	// Compare and report
	// *****
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	task automatic check_bit(input string name, input logic exp, input logic got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %b, seen %b", name, exp, got);
		end
	endtask

	task automatic end_sim();
		$display("comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// *****
	// Shift helpers
	// *****
	// Six cycles covers the three-flop pin path plus the register stage;
	// read on the falling edge so the outputs launched at the last rise have settled
	task automatic settle();
		host.wait_clk(6);
		@(negedge sys_clk);
	endtask

	task automatic shift_one(input logic b);
		logic old;
		old = exp_stages[7];
		host.rise(b);
		settle();
		check_bit("cascade on rise", old, cascade_out);
		exp_stages = {exp_stages[6:0], b};
		host.fall();
		settle();
		check_bit("cascade after fall", exp_stages[7], cascade_out);
	endtask

	task automatic shift_byte(input logic [7:0] v);
		for (int i = 7; i >= 0; i--) begin
			shift_one(v[i]);
		end
	endtask

	// *****
	// Scenarios
	// *****
	task automatic test_clear_hold();
		settle();
		check("oe under clear", 8'h00, led_sink_oe);
		check_bit("cascade under clear", 1'b0, cascade_out);
		host.set_ctl(1'b0, 1'b0, 1'b1);
		settle();
		check("oe after release", 8'h00, led_sink_oe);
		$display("test clear_hold done");
	endtask

	task automatic test_hold_latch();
		shift_byte(8'hc1);
		check("oe while held", 8'h00, led_sink_oe);
		host.set_ctl(1'b1, 1'b0, 1'b1);
		settle();
		check("oe after latch", 8'hc1, led_sink_oe);
		check("sink data", 8'h00, led_sink_out);
		$display("test hold_latch done");
	endtask

	task automatic test_transparent();
		shift_one(1'b0);
		check("oe transparent", exp_stages, led_sink_oe);
		shift_one(1'b1);
		check("oe transparent", exp_stages, led_sink_oe);
		host.set_ctl(1'b0, 1'b0, 1'b1);
		settle();
		shift_one(1'b1);
		check("oe frozen", 8'h05, led_sink_oe);
		$display("test transparent done");
	endtask

	task automatic test_disable();
		host.set_ctl(1'b0, 1'b1, 1'b1);
		settle();
		check("oe disabled", 8'h00, led_sink_oe);
		shift_one(1'b0);
		host.set_ctl(1'b0, 1'b0, 1'b1);
		settle();
		check("oe enabled", 8'h05, led_sink_oe);
		host.set_ctl(1'b1, 1'b0, 1'b1);
		settle();
		check("oe after toggle", exp_stages, led_sink_oe);
		$display("test disable done");
	endtask

	task automatic test_clear_mid();
		shift_byte(8'h81);
		check("oe before clear", 8'h81, led_sink_oe);
		// Bits five to twelve since the last clear overflowed into the next device
		check("chained oe", 8'h16, next_oe);
		host.set_ctl(1'b1, 1'b0, 1'b0);
		settle();
		check("oe cleared", 8'h00, led_sink_oe);
		check_bit("cascade cleared", 1'b0, cascade_out);
		exp_stages = 8'h00;
		host.set_ctl(1'b1, 1'b0, 1'b1);
		settle();
		check("ranks empty", 8'h00, led_sink_oe);
		$display("test clear_mid done");
	endtask

	// Hang guard: a run far past its length counts as a mismatch
	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		end_sim();
	end

	initial begin
		sys_clk    = 1'b0;
		reset_n    = 1'b0;
		failures   = 0;
		tests_run  = 0;
		exp_stages = 8'h00;
		repeat (20) @(posedge sys_clk);
		reset_n <= 1'b1;
		test_clear_hold();
		test_hold_latch();
		test_transparent();
		test_disable();
		test_clear_mid();
		end_sim();
	end
endmodule

`default_nettype wire
